// file: cfm_move_unit.sv
`timescale 1ns/10ps
// ==============================
// character field move unit

// Contract
// - two-bit condition register updated at finish
// - condition register cleared at instruction start
// - condition drives zero, high, low jumps
// - character is four-bit digit plus zone
// - sign from rightmost zone, others zero
// - packed sign 1010 positive, 1011 negative
// - zone 10 negative, all else positive
// - flag 1,3 index one; 2 two
// - field addresses point at highest-order character
// - plain move stops at shorter length
// - plain, blank fill: 00 positive, 10 negative
// - destination count kept in index bits 0-11
// - delimited move stops after matching character
// - delimited move leaves condition at 00
// - blank fill pads longer destination
// - zero fill clears zones, forces 12-17 zero
// - zero fill stops shorter, pads with zeros
// - zero fill always copies source sign; code leaves condition at 00 when interrupted
// - zero fill flags bad zone, digit, sign
// - numeric fault does not abort move
// - zero suppress blanks leading zeros only
// - zero suppress leaves zones untouched
// - zero suppress sign only when moved; code uses last moved char if source not shorter
// - interrupt sets index bit 14 on fault
module cfm_move_unit (
  // clock and reset
  input  logic        I_CLK,
  input  logic        I_RESET,
  // instruction issue from main control
  input  logic        I_START,
  input  logic [2:0]  I_MODE,
  input  logic [19:0] I_R_ADDR,
  input  logic [1:0]  I_R_FLAG,
  input  logic [19:0] I_S_ADDR,
  input  logic [1:0]  I_S_FLAG,
  input  logic [11:0] I_LEN1,
  input  logic [11:0] I_LEN2,
  input  logic [5:0]  I_DELIM,
  input  logic [19:0] I_INDEX1,
  input  logic [19:0] I_INDEX2,
  input  logic        I_INT_STOP,
  // memory read
  output logic        O_RD_REQ,
  output logic [19:0] O_RD_ADDR,
  input  logic        I_RD_VALID,
  input  logic [5:0]  I_RD_DATA,
  // memory write
  output logic        O_WR_REQ,
  output logic [19:0] O_WR_ADDR,
  output logic [5:0]  O_WR_DATA,
  input  logic        I_WR_ACK,
  // status
  output logic        O_BUSY,
  output logic        O_DONE,
  output logic        O_INTERRUPTED,
  output logic [1:0]  O_COND_CODE,
  output logic        O_JMP_ZERO,
  output logic        O_JMP_HIGH,
  output logic        O_JUMP_ON_COND_LOW,
  output logic [3:0]  O_PACKED_SIGN,
  output logic [14:0] O_INDEX3,
  output logic        O_NUM_FAULT
);

  // ==============================
  // state
  typedef enum logic [2:0] {ST_IDLE, ST_SIGN, ST_MOVE, ST_FILL, ST_DRAIN} cfm_state_t;

  typedef struct packed {
    cfm_state_t  st;
    logic        busy;
    logic        done;
    logic        intr;
    logic [2:0]  mode;
    logic [19:0] src_a;
    logic [19:0] dst_a;
    logic [19:0] rd_addr;
    logic [19:0] wr_addr;
    logic [11:0] len1;
    logic [11:0] len2;
    logic [11:0] nmove;
    logic [11:0] rd_cnt;
    logic [5:0]  delim;
    logic [5:0]  wr_data;
    logic        rd_req;
    logic        wr_req;
    logic        fault;
    logic        sign_neg;
    logic        supp;
    logic        delim_hit;
    logic [1:0]  cc;
    logic        jmp_zero;
    logic        jmp_high;
    logic        jump_on_cond_low;
    logic [3:0]  psign;
    logic [14:0] idx3;
  } cfm_move_st_t;

  cfm_move_st_t q;
  cfm_move_st_t n;
  logic [19:0]  a_r;
  logic [19:0]  a_s;
  logic [11:0]  mv;
  logic [5:0]   ch;
  logic         last_src;
  logic         last_dst;
  logic [1:0]   szone;

  cfm_fifo_if #(.W(cfm_pkg::FIFO_W)) fq ();

  // ==============================
  // helpers

  // base plus selected index register
  function automatic logic [19:0] eff_addr(input logic [19:0] a, input logic [1:0] f,
                                           input logic [19:0] x1, input logic [19:0] x2);
    if (f == cfm_pkg::FLAG_NONE) begin
      eff_addr = a;
    end else if (f == cfm_pkg::FLAG_IDX2) begin
      eff_addr = a + x2;
    end else begin
      eff_addr = a + x1;
    end
  endfunction

  function automatic logic is_neg(input logic [5:0] c);
    is_neg = (c[5:4] == cfm_pkg::ZONE_NEG);
  endfunction

  // zoneless digit; codes above nine become zero, sign zone goes last
  // digits stop at nine
  function automatic logic [5:0] zf_char(input logic [5:0] c, input logic last,
                                         input logic [1:0] z);
    zf_char = {last ? z : cfm_pkg::ZONE_NONE,
               (c[3:0] > cfm_pkg::DIGIT_MAX) ? cfm_pkg::DIGIT_ZERO : c[3:0]};
  endfunction

  function automatic logic is_fill(input logic [2:0] m);
    is_fill = (m == cfm_pkg::OP_BLANK) || (m == cfm_pkg::OP_ZFILL);
  endfunction

  // ==============================
  // queue between reader and writer
  cfm_fifo #(
    .W     (cfm_pkg::FIFO_W),
    .DEPTH (cfm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .I_CLK   (I_CLK),
    .I_RESET (I_RESET),
    .f       (fq.fifo)
  );

  // ==============================
  // next state
  always_comb begin
    n             = q;
    n.done        = 1'b0;
    fq.in_valid   = 1'b0;
    fq.out_ready  = 1'b0;
    fq.flush      = 1'b0;
    last_src      = (q.rd_cnt == q.len1 - 12'h001);
    fq.in_data    = {last_src, I_RD_DATA};
    ch            = fq.out_data[5:0];
    last_dst      = (q.idx3[11:0] == q.len2 - 12'h001);
    szone         = q.sign_neg ? cfm_pkg::ZONE_NEG : cfm_pkg::ZONE_NONE;
    a_r           = eff_addr(I_R_ADDR, I_R_FLAG, I_INDEX1, I_INDEX2);
    a_s           = eff_addr(I_S_ADDR, I_S_FLAG, I_INDEX1, I_INDEX2);
    mv            = (I_LEN1 < I_LEN2) ? I_LEN1 : I_LEN2;
    // a read answer always retires the request, whatever the state
    if (q.rd_req && I_RD_VALID) begin
      n.rd_req = 1'b0;
    end
    case (q.st)
      ST_IDLE: begin
        if (I_START) begin
          n.busy      = 1'b1;
          n.intr      = 1'b0;
          n.mode      = I_MODE;
          // both addresses name the leftmost character
          n.src_a     = a_r;
          n.dst_a     = a_s;
          n.len1      = (I_MODE == cfm_pkg::OP_DELIM) ? I_LEN2 : I_LEN1;
          n.len2      = I_LEN2;
          n.nmove     = (I_MODE == cfm_pkg::OP_DELIM) ? I_LEN2 : mv;
          n.rd_cnt    = '0;
          n.idx3      = '0;
          n.delim     = I_DELIM;
          n.sign_neg  = 1'b0;
          n.supp      = 1'b1;
          n.delim_hit = 1'b0;
          // fault lives until the next start
          n.fault     = 1'b0;
          n.cc        = cfm_pkg::CC_RESET;
          // zero fill with a nonzero source length fetches the sign character first
          if (I_MODE == cfm_pkg::OP_ZFILL && I_LEN1 != '0) begin
            n.st      = ST_SIGN;
            n.rd_req  = 1'b1;
            n.rd_addr = a_r + {8'h00, I_LEN1} - 20'h00001;
          end else if (n.nmove == '0) begin
            n.st      = is_fill(I_MODE) ? ST_FILL : ST_DRAIN;
          end else begin
            n.st      = ST_MOVE;
          end
        end
      end
      ST_SIGN: begin
        if (q.rd_req && I_RD_VALID) begin
          // sign lives in the rightmost zone
          n.sign_neg = is_neg(I_RD_DATA);
          // sign character allows digit 12 octal, never 72 octal
          if (I_RD_DATA[3:0] > cfm_pkg::SIGN_DIGIT_MAX || I_RD_DATA == cfm_pkg::SIGN_BAD) begin
            n.fault = 1'b1;
          end
          n.st = (q.nmove == '0) ? ST_FILL : ST_MOVE;
        end
      end
      ST_MOVE: begin
        // reader: one read in flight, issued only with queue room
        if (q.rd_req && I_RD_VALID) begin
          fq.in_valid = 1'b1;
          n.src_a     = q.src_a + 20'h00001;
          n.rd_cnt    = q.rd_cnt + 12'h001;
        end else if (!q.rd_req && q.rd_cnt != q.nmove && fq.in_ready
                     && !I_INT_STOP && !q.delim_hit) begin
          n.rd_req  = 1'b1;
          n.rd_addr = q.src_a;
        end
        // writer: one character at a time, stops only between characters
        if (q.wr_req) begin
          if (I_WR_ACK) begin
            n.wr_req        = 1'b0;
            n.dst_a         = q.dst_a + 20'h00001;
            n.idx3[11:0]    = q.idx3[11:0] + 12'h001;
            // end after the delimiter itself is written
            if (q.idx3[11:0] + 12'h001 == q.nmove || q.delim_hit) begin
              n.st = (is_fill(q.mode) && !q.delim_hit) ? ST_FILL : ST_DRAIN;
            end else if (I_INT_STOP) begin
              n.intr = 1'b1;
              n.st   = ST_DRAIN;
            end
          end
        end else if (I_INT_STOP) begin
          n.intr = 1'b1;
          n.st   = ST_DRAIN;
        end else if (fq.out_valid) begin
          fq.out_ready = 1'b1;
          n.wr_req     = 1'b1;
          n.wr_addr    = q.dst_a;
          n.wr_data    = ch;
          case (q.mode)
            cfm_pkg::OP_ZFILL: begin
              // zones dropped, codes 12-17 octal written as zero
              n.wr_data = zf_char(ch, last_dst, szone);
              // body characters need zero zone and a real digit
              // the fault is only recorded, the move goes on
              if (!fq.out_data[6] && (ch[5:4] != cfm_pkg::ZONE_NONE || ch[3:0] > cfm_pkg::DIGIT_MAX)) begin
                n.fault = 1'b1;
              end
            end
            cfm_pkg::OP_ZSUPP: begin
              // leading zeros become blanks until a non-zero
              if (q.supp && ch == cfm_pkg::ZERO_CHAR) begin
                n.wr_data = cfm_pkg::BLANK_CHAR;
              end else begin
                n.supp = 1'b0;
              end
              n.sign_neg = is_neg(ch);
            end
            cfm_pkg::OP_DELIM: begin
              if (ch == q.delim) begin
                n.delim_hit = 1'b1;
              end
            end
            default: begin
              // sign taken only when the last source moves
              if (fq.out_data[6]) begin
                n.sign_neg = is_neg(ch);
              end
            end
          endcase
        end
      end
      ST_FILL: begin
        if (q.wr_req) begin
          if (I_WR_ACK) begin
            n.wr_req     = 1'b0;
            n.dst_a      = q.dst_a + 20'h00001;
            n.idx3[11:0] = q.idx3[11:0] + 12'h001;
          end
        end else if (q.idx3[11:0] == q.len2) begin
          n.st = ST_DRAIN;
        end else if (I_INT_STOP) begin
          n.intr = 1'b1;
          n.st   = ST_DRAIN;
        end else begin
          n.wr_req  = 1'b1;
          n.wr_addr = q.dst_a;
          // blank pad in blank fill, else zero pad with sign zone on the last position
          n.wr_data = (q.mode == cfm_pkg::OP_BLANK) ? cfm_pkg::BLANK_CHAR
                                                    : zf_char(cfm_pkg::ZERO_CHAR, last_dst, szone);
        end
      end
      ST_DRAIN: begin
        // wait for a stray read answer so the next instruction sees none
        if (!q.rd_req) begin
          fq.flush = 1'b1;
          n.st     = ST_IDLE;
          n.busy   = 1'b0;
          n.done   = 1'b1;
          n.idx3[cfm_pkg::IDX3_FAULT_BIT] = q.intr && q.fault;
          if (!q.intr) begin
            case (q.mode)
              // delimited move never sets a sign
              cfm_pkg::OP_DELIM: n.cc = cfm_pkg::CC_POS;
              // sign from the last moved character, only when the source is not shorter
              cfm_pkg::OP_ZSUPP: n.cc = (q.len1 >= q.len2 && q.sign_neg) ? cfm_pkg::CC_NEG : cfm_pkg::CC_POS;
              default:           n.cc = q.sign_neg ? cfm_pkg::CC_NEG : cfm_pkg::CC_POS;
            endcase
          end
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
    // jump conditions follow the condition register
    n.jmp_zero = (n.cc == cfm_pkg::CC_POS);
    n.jmp_high = (n.cc == cfm_pkg::CC_HIGH);
    n.jump_on_cond_low  = (n.cc == cfm_pkg::CC_NEG);
    // packed sign code for the result
    n.psign    = (n.cc == cfm_pkg::CC_NEG) ? cfm_pkg::PACK_NEG : cfm_pkg::PACK_POS;
  end

  // ==============================
  // state register
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      q          <= '0;
      q.jmp_zero <= 1'b1;
      q.psign    <= cfm_pkg::PACK_POS;
    end else begin
      q <= n;
    end
  end

  // outputs straight from the state register
  assign O_RD_REQ      = q.rd_req;
  assign O_RD_ADDR     = q.rd_addr;
  assign O_WR_REQ      = q.wr_req;
  assign O_WR_ADDR     = q.wr_addr;
  assign O_WR_DATA     = q.wr_data;
  assign O_BUSY        = q.busy;
  assign O_DONE        = q.done;
  assign O_INTERRUPTED = q.intr;
  assign O_COND_CODE   = q.cc;
  assign O_JMP_ZERO    = q.jmp_zero;
  assign O_JMP_HIGH    = q.jmp_high;
  assign O_JUMP_ON_COND_LOW     = q.jump_on_cond_low;
  assign O_PACKED_SIGN = q.psign;
  assign O_INDEX3      = q.idx3;
  assign O_NUM_FAULT   = q.fault;

  // ==============================
  // checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);

  cc_clear_a : assert property (I_START && !q.busy |=> q.cc == cfm_pkg::CC_POS)
    else $error("condition not cleared at start");
  delim_cc_a : assert property (q.done && q.mode == cfm_pkg::OP_DELIM |-> q.cc == cfm_pkg::CC_POS)
    else $error("delimited move changed condition");
  zf_sign_a : assert property (q.done && !q.intr && q.mode == cfm_pkg::OP_ZFILL
                               |-> (q.cc == cfm_pkg::CC_NEG) == q.sign_neg)
    else $error("zero fill sign not copied");
  zf_zone_a : assert property (q.wr_req && q.mode == cfm_pkg::OP_ZFILL && !last_dst
                               |-> q.wr_data[5:4] == cfm_pkg::ZONE_NONE)
    else $error("zero fill left a zone");
  dst_bound_a : assert property (q.wr_req |-> q.idx3[11:0] < q.len2)
    else $error("write past destination length");
  fault_hold_a : assert property (q.fault && !(I_START && !q.busy) |=> q.fault)
    else $error("fault dropped early");
  int_fault_a : assert property (q.done && q.intr |-> q.idx3[cfm_pkg::IDX3_FAULT_BIT] == q.fault)
    else $error("interrupt fault bit wrong");
  addr_plain_a : assert property (I_START && !q.busy && I_R_FLAG == cfm_pkg::FLAG_NONE
                                  |=> q.src_a == $past(I_R_ADDR))
    else $error("unindexed address altered");
  blank_pad_a : assert property (q.wr_req && q.st == ST_FILL && q.mode == cfm_pkg::OP_BLANK
                                 |-> q.wr_data == cfm_pkg::BLANK_CHAR)
    else $error("blank fill wrote non-blank");
  jump_low_a : assert property (q.done && !q.intr && q.mode != cfm_pkg::OP_DELIM
                                && q.mode != cfm_pkg::OP_ZSUPP |-> q.jump_on_cond_low == q.sign_neg)
    else $error("low jump disagrees with sign");

endmodule // cfm_move_unit

// file: cfm_pkg.sv
// ==============================
// character field move constants
package cfm_pkg;

  // widths
  localparam int CHAR_W         = 6;
  localparam int ADDR_W         = 20;
  localparam int LEN_W          = 12;
  localparam int IDX3_W         = 15;
  localparam int IDX3_FAULT_BIT = 14;
  localparam int FIFO_DEPTH     = 8;
  localparam int FIFO_W         = CHAR_W + 1;

  // zone and condition codes
  localparam logic [1:0] ZONE_NONE = 2'h0;
  localparam logic [1:0] ZONE_NEG  = 2'h2;
  localparam logic [1:0] CC_POS    = 2'h0;
  localparam logic [1:0] CC_HIGH   = 2'h1;
  localparam logic [1:0] CC_NEG    = 2'h2;
  localparam logic [1:0] CC_RESET  = CC_POS;

  // digit and character codes
  localparam logic [3:0] PACK_POS       = 4'hA;
  localparam logic [3:0] PACK_NEG       = 4'hB;
  localparam logic [3:0] DIGIT_MAX      = 4'h9;
  localparam logic [3:0] SIGN_DIGIT_MAX = 4'hA;
  localparam logic [3:0] DIGIT_ZERO     = 4'h0;
  localparam logic [5:0] SIGN_BAD       = 6'h3A;
  localparam logic [5:0] BLANK_CHAR     = 6'h30;
  localparam logic [5:0] ZERO_CHAR      = 6'h00;

  // index flag codes
  localparam logic [1:0] FLAG_NONE = 2'h0;
  localparam logic [1:0] FLAG_IDX2 = 2'h2;

  // operation codes on the command port
  localparam logic [2:0] OP_MOVE  = 3'h0;
  localparam logic [2:0] OP_DELIM = 3'h1;
  localparam logic [2:0] OP_BLANK = 3'h2;
  localparam logic [2:0] OP_ZFILL = 3'h3;
  localparam logic [2:0] OP_ZSUPP = 3'h4;

endpackage

// file: cfm_fifo_if.sv
`timescale 1ns/10ps
// ==============================
// character queue carrier
interface cfm_fifo_if #(parameter int W = 7);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  logic         flush;
  modport user (output in_valid, in_data, out_ready, flush,
                input  in_ready, out_valid, out_data);
  modport fifo (input  in_valid, in_data, out_ready, flush,
                output in_ready, out_valid, out_data);
endinterface

// file: cfm_fifo.sv
`timescale 1ns/10ps
// ==============================
// source character queue
module cfm_fifo #(
  parameter int W     = 7,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  logic I_CLK,
  input  logic I_RESET,
  // queue ports
  cfm_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } cfm_fifo_st_t;

  cfm_fifo_st_t q;
  cfm_fifo_st_t n;
  logic         push;
  logic         pop;

  // flags come from the count, so full and empty never disagree
  assign f.in_ready  = (q.cnt != (AW+1)'(DEPTH));
  assign f.out_valid = (q.cnt != '0);
  assign f.out_data  = q.mem[q.rp];

  // next state
  always_comb begin
    n    = q;
    push = f.in_valid && f.in_ready;
    pop  = f.out_valid && f.out_ready;
    if (f.flush) begin
      n.wp  = '0;
      n.rp  = '0;
      n.cnt = '0;
    end else begin
      if (push) begin
        n.mem[q.wp] = f.in_data;
        n.wp        = q.wp + AW'(1);
      end
      if (pop) begin
        n.rp = q.rp + AW'(1);
      end
      n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // state register
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);

  full_count_a : assert property (!f.in_ready |-> q.cnt == (AW+1)'(DEPTH))
    else $error("queue refuses while not full");
  push_count_a : assert property (push && !pop && !f.flush |=> q.cnt == $past(q.cnt) + 1)
    else $error("queue count missed a push");

endmodule // cfm_fifo

// file: cfm_mem_model.sv
`timescale 1ns/10ps
// ==============================
// main control and core memory stand-in
module cfm_mem_model (
  // clock
  input  wire logic        I_CLK,
  // read side
  input  wire logic        i_rd_req,
  input  wire logic [19:0] i_rd_addr,
  output      logic        o_rd_valid,
  output      logic [5:0]  o_rd_data,
  // write side
  input  wire logic        i_wr_req,
  input  wire logic [19:0] i_wr_addr,
  input  wire logic [5:0]  i_wr_data,
  output      logic        o_wr_ack
);
  logic [5:0] mem [int];
  int         rlo, rhi, wlo, whi, rd_bad, wr_bad, wr_n, rw, ww, slow;

  // ==============================
  // answers
  // quiet state at time zero
  initial begin
    o_rd_valid = 1'b0;
    o_rd_data = 6'h15;
    o_wr_ack = 1'b0;
    rw = 0;
    ww = 0;
    slow = 0;
  end

  // reads answered after a random stall; idle data toggles so a stale value never matches
  always @(posedge I_CLK) begin
    if (i_rd_req && !o_rd_valid && rw == 0) begin
      o_rd_valid <= 1'b1;
      o_rd_data <= mem[i_rd_addr];
      if (i_rd_addr < rlo || i_rd_addr > rhi) rd_bad++;
      rw = $urandom % 3;
    end else begin
      o_rd_valid <= 1'b0;
      o_rd_data <= ~o_rd_data;
      if (i_rd_req && !o_rd_valid) rw--;
    end
  end

  // writes stored at acknowledge; slow mode lets the read queue fill up
  always @(posedge I_CLK) begin
    if (i_wr_req && !o_wr_ack && ww == 0) begin
      o_wr_ack <= 1'b1;
      mem[i_wr_addr] = i_wr_data;
      wr_n++;
      if (i_wr_addr < wlo || i_wr_addr > whi) wr_bad++;
      ww = $urandom % (slow ? 8 : 3);
    end else begin
      o_wr_ack <= 1'b0;
      if (i_wr_req && !o_wr_ack) ww--;
    end
  end
endmodule // cfm_mem_model

// file: char_field_move_unit_tb_top.sv
`timescale 1ns/10ps
// ==============================
// bench for the character field move unit
module char_field_move_unit_tb_top;
  logic        clk, rst, start, int_stop, rd_req, rd_valid, wr_req, wr_ack, busy, done, intr, jz, jh, jl, fault;
  logic [2:0]  mode;
  logic [19:0] raddr, saddr, idx1, idx2, rd_addr, wr_addr;
  logic [1:0]  rflag, sflag, cc, exp_cc;
  logic [11:0] len1, len2;
  logic [5:0]  delim, rd_data, wr_data;
  logic [3:0]  psign;
  logic [14:0] idx3;
  logic [5:0]  src [64];
  logic [5:0]  exp_d [64];
  logic        exp_f;
  int          exp_w, bad_count, n_tests, a, hung;

  cfm_move_unit cfm_move_unit_inst (.I_CLK(clk), .I_RESET(rst), .I_START(start), .I_MODE(mode),
    .I_R_ADDR(raddr), .I_R_FLAG(rflag), .I_S_ADDR(saddr), .I_S_FLAG(sflag), .I_LEN1(len1), .I_LEN2(len2),
    .I_DELIM(delim), .I_INDEX1(idx1), .I_INDEX2(idx2), .I_INT_STOP(int_stop), .O_RD_REQ(rd_req),
    .O_RD_ADDR(rd_addr), .I_RD_VALID(rd_valid), .I_RD_DATA(rd_data), .O_WR_REQ(wr_req), .O_WR_ADDR(wr_addr),
    .O_WR_DATA(wr_data), .I_WR_ACK(wr_ack), .O_BUSY(busy), .O_DONE(done), .O_INTERRUPTED(intr),
    .O_COND_CODE(cc), .O_JMP_ZERO(jz), .O_JMP_HIGH(jh), .O_JUMP_ON_COND_LOW(jl), .O_PACKED_SIGN(psign),
    .O_INDEX3(idx3), .O_NUM_FAULT(fault));
  cfm_mem_model cfm_mem_model_inst (.I_CLK(clk), .i_rd_req(rd_req), .i_rd_addr(rd_addr), .o_rd_valid(rd_valid),
    .o_rd_data(rd_data), .i_wr_req(wr_req), .i_wr_addr(wr_addr), .i_wr_data(wr_data), .o_wr_ack(wr_ack));

  // ==============================
  // clock of 50 ns
  always #25 clk = ~clk;

  // compare and count
  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] want);
    n_tests++;
    if (seen !== want) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask

  // verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ==============================
  // expected destination, condition, count and fault; 6'h2A marks untouched places
  function automatic void predict(input logic [2:0] m, input int l1, input int l2, input logic [5:0] dl);
    int   n;
    logic lead;
    n = l1 < l2 ? l1 : l2;
    lead = 1'b1;
    exp_w = n;
    exp_cc = cfm_pkg::CC_POS;
    exp_f = 1'b0;
    foreach (exp_d[i]) exp_d[i] = 6'h2A;
    case (m)
      cfm_pkg::OP_DELIM: begin
        exp_w = 0;
        for (int i = 0; i < l2 && (i == 0 || src[i-1] != dl); i++) begin
          exp_d[i] = src[i];
          exp_w++;
        end
      end
      cfm_pkg::OP_ZFILL: begin
        exp_w = l2;
        for (int i = 0; i < l2; i++) exp_d[i] = (i < n && src[i][3:0] <= cfm_pkg::DIGIT_MAX) ?
          {2'b00, src[i][3:0]} : cfm_pkg::ZERO_CHAR;
        for (int i = 0; i < n; i++) if (i != l1 - 1 && (src[i][5:4] != cfm_pkg::ZONE_NONE ||
          src[i][3:0] > cfm_pkg::DIGIT_MAX)) exp_f = 1'b1;
        if (src[l1-1][3:0] > cfm_pkg::SIGN_DIGIT_MAX || src[l1-1] == cfm_pkg::SIGN_BAD) exp_f = 1'b1;
        if (src[l1-1][5:4] == cfm_pkg::ZONE_NEG) begin
          exp_cc = cfm_pkg::CC_NEG;
          exp_d[l2-1][5:4] = cfm_pkg::ZONE_NEG;
        end
      end
      cfm_pkg::OP_ZSUPP: begin
        for (int i = 0; i < n; i++) begin
          lead = lead && src[i] == cfm_pkg::ZERO_CHAR;
          exp_d[i] = lead ? cfm_pkg::BLANK_CHAR : src[i];
        end
        if (l1 >= l2 && n > 0 && src[n-1][5:4] == cfm_pkg::ZONE_NEG) exp_cc = cfm_pkg::CC_NEG;
      end
      default: begin
        for (int i = 0; i < n; i++) exp_d[i] = src[i];
        if (l1 <= l2 && l1 > 0 && src[l1-1][5:4] == cfm_pkg::ZONE_NEG) exp_cc = cfm_pkg::CC_NEG;
        if (m == cfm_pkg::OP_BLANK) begin
          for (int i = n; i < l2; i++) exp_d[i] = cfm_pkg::BLANK_CHAR;
          exp_w = l2;
        end
      end
    endcase
  endfunction

  // one instruction; stop > 0 raises the interrupt stop, stop < 0 tries a start while busy
  task automatic run(input logic [2:0] m, input int l1, input int l2, input int stop, input int sl);
    logic [19:0] r, s, x1, x2, rr, ss;
    logic [1:0]  fr, fs;
    logic [5:0]  dl;
    int          k;
    // after a hang the rest is skipped and the verdict reports it
    if (hung) return;
    fr = 2'($urandom);
    fs = 2'($urandom);
    x1 = $urandom % 4096;
    x2 = $urandom % 4096;
    r = 20'h01000 + $urandom % 256;
    s = 20'h40000 + $urandom % 256;
    // odd digits keep the first nonzero character clearly not a zero
    foreach (src[i]) src[i] = ($urandom % 4 == 0) ? cfm_pkg::ZERO_CHAR : (6'($urandom) | 6'h01);
    dl = src[$urandom % 24];
    if (stop > 0) src[l1-1] = cfm_pkg::SIGN_BAD;
    // flag 2 picks the second index, 1 and 3 the first
    rr = r + (fr == cfm_pkg::FLAG_NONE ? 20'h0 : fr == cfm_pkg::FLAG_IDX2 ? x2 : x1);
    ss = s + (fs == cfm_pkg::FLAG_NONE ? 20'h0 : fs == cfm_pkg::FLAG_IDX2 ? x2 : x1);
    cfm_mem_model_inst.mem.delete();
    for (k = 0; k < 64; k++) begin
      cfm_mem_model_inst.mem[rr + k] = src[k];
      cfm_mem_model_inst.mem[ss + k] = 6'h2A;
    end
    cfm_mem_model_inst.rlo = rr;
    cfm_mem_model_inst.rhi = rr + (m == cfm_pkg::OP_DELIM ? l2 : l1) - 1;
    cfm_mem_model_inst.wlo = ss;
    cfm_mem_model_inst.whi = ss + l2 - 1;
    cfm_mem_model_inst.rd_bad = 0;
    cfm_mem_model_inst.wr_bad = 0;
    cfm_mem_model_inst.wr_n = 0;
    cfm_mem_model_inst.slow = sl;
    predict(m, l1, l2, dl);
    @(posedge clk);
    mode <= m;
    raddr <= r;
    saddr <= s;
    rflag <= fr;
    sflag <= fs;
    idx1 <= x1;
    idx2 <= x2;
    len1 <= 12'(l1);
    len2 <= 12'(l2);
    delim <= dl;
    int_stop <= 1'b0;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1;
    check("busy", busy, 1'b1);
    check("cc at start", cc, cfm_pkg::CC_POS);
    check("fault at start", fault, 1'b0);
    for (k = 0; k < 3000; k++) begin
      @(posedge clk);
      start <= (stop < 0 && k == 2);
      int_stop <= (stop > 0 && k >= stop);
      #1;
      if (done === 1'b1) break;
    end
    if (k == 3000) begin
      bad_count++;
      hung = 1;
      return;
    end
    if (stop > 0) begin
      check("stopped", intr, 1'b1);
      check("fault bit", idx3[14], 1'b1);
      check("fault held", fault, 1'b1);
      check("stop count", idx3[11:0], 12'(cfm_mem_model_inst.wr_n));
      check("stop cc", cc, cfm_pkg::CC_POS);
    end else begin
      for (k = 0; k <= l2; k++) check("dest", cfm_mem_model_inst.mem[ss + k], exp_d[k]);
      check("cc", cc, exp_cc);
      check("jump zero", jz, exp_cc == cfm_pkg::CC_POS);
      check("jump low", jl, exp_cc == cfm_pkg::CC_NEG);
      check("jump high", jh, 1'b0);
      check("packed", psign, exp_cc == cfm_pkg::CC_NEG ? cfm_pkg::PACK_NEG : cfm_pkg::PACK_POS);
      check("count", idx3, 15'(exp_w));
      check("writes", 20'(cfm_mem_model_inst.wr_n), 20'(exp_w));
      check("fault", fault, exp_f);
      check("stray", 20'(cfm_mem_model_inst.rd_bad + cfm_mem_model_inst.wr_bad), 20'h0);
      check("stopped", intr, 1'b0);
    end
  endtask

  // ==============================
  // main sequence
  initial begin
    {clk, rst, start, int_stop, mode, raddr, saddr, rflag, sflag} = '0;
    {len1, len2, delim, idx1, idx2} = '0;
    rst = 1'b1;
    bad_count = 0;
    hung = 0;
    n_tests = 0;
    void'($urandom(32'h3fe5));
    repeat (4) @(posedge clk);
    #1;
    check("reset cc", cc, cfm_pkg::CC_RESET);
    check("reset packed", psign, cfm_pkg::PACK_POS);
    @(posedge clk);
    rst <= 1'b0;
    run(cfm_pkg::OP_MOVE, 0, 5, 0, 0);
    run(cfm_pkg::OP_DELIM, 3, 0, 0, 0);
    run(cfm_pkg::OP_ZFILL, 30, 30, 12, 0);
    // every mode, equal and unequal lengths, slow writes half the time
    for (int t = 0; t < 40; t++) begin
      a = 1 + $urandom % 24;
      run(3'(t % 5), a, (t % 4 == 0) ? a : 1 + $urandom % 24, (t == 7) ? -1 : 0, t % 2);
    end
    conclude();
  end
endmodule // char_field_move_unit_tb_top
